//--- logic/dtr_device.sv
`timescale 1ns/10ps
// Summary of operation
// - new driver calibration or termination mode is taken at the command edge and reaches the core two mclk edges later.
// - mode bit A12 picks fast (0) or slow (1) active power-down exit.
// - complementary strobe is always the inverse; it floats with the strobe, or alone when disabled.
// - outputs start and stop driving in the data transition windows.
module dtr_device
  import dtr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic link_ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe_n,
  output logic dqs_out,
  output logic dqs_oe_n,
  output logic dqs_n_out,
  output logic dqs_n_oe_n,
  output logic core_apd_slow,
  output logic [2:0] core_ocd_mode,
  output logic core_odt_on,
  output logic core_self_refresh,
  output logic core_power_down,
  output logic core_refresh_pulse,
  output logic [15:0] core_refresh_count
);
  logic [1:0] rst_ck_q;
  logic rst_ck_n;
  logic [3:0] cmd;
  logic cmd_ok;
  logic pd_slow_q;
  logic [2:0] cl_q;
  logic [2:0] bl_q;
  logic [2:0] al_q;
  logic [2:0] ocd_q;
  logic [1:0] rtt_q;
  logic dqsn_dis_q;
  logic row_open_q;
  logic sref_q;
  logic pdn_q;
  logic ref_tgl_q;
  dtr_state_e state_q;
  logic [3:0] wait_q;
  logic [3:0] beat_q;
  logic [3:0] beats;
  logic [3:0] rl;
  logic [DQ_W-1:0] mem_q [0:7];
  logic [STAT_W-1:0] stat_ck;
  logic [STAT_W-1:0] stat_s1_q;
  logic [STAT_W-1:0] stat_s2_q;
  logic [2:0] ref_sync_q;
  logic [15:0] ref_cnt_q;
  logic ref_pulse_q;

  // reset release synchronised into the link domain
  always_ff @(posedge link_ck or negedge reset_n)
  begin
    if (!reset_n)
      rst_ck_q <= 2'h0;
    else
      rst_ck_q <= {rst_ck_q[0], 1'b1};
  end
  assign rst_ck_n = rst_ck_q[1];

  // command decode, ignored while clock enable is low
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign cmd_ok = cke && !sref_q && !pdn_q;
  assign beats = (bl_q == BL_CODE_8) ? BEATS_8 : BEATS_4;
  assign rl = {1'b0, cl_q} + {1'b0, al_q};

  // mode register: power-down exit select, cas latency, burst length
  always_ff @(posedge link_ck or negedge rst_ck_n)
  begin
    if (!rst_ck_n)
    begin
      pd_slow_q <= 1'b0;
      cl_q <= CL_RESET;
      bl_q <= 3'h2;
    end
    else if (cmd_ok && cmd == CMD_MRS && ba == BA_MR)
    begin
      pd_slow_q <= addr[MR_PD_BIT];
      cl_q <= addr[MR_CL_LSB +: 3];
      bl_q <= addr[MR_BL_LSB +: 3];
    end
  end

  // extended mode register, takes effect at the command edge
  always_ff @(posedge link_ck or negedge rst_ck_n)
  begin
    if (!rst_ck_n)
    begin
      ocd_q <= OCD_RESET;
      rtt_q <= RTT_RESET;
      al_q <= AL_RESET;
      dqsn_dis_q <= 1'b0;
    end
    else if (cmd_ok && cmd == CMD_MRS && ba == BA_EMR)
    begin
      ocd_q <= addr[EMR_OCD_LSB +: 3];
      rtt_q <= {addr[EMR_RTT_HI], addr[EMR_RTT_LO]};
      al_q <= addr[EMR_AL_LSB +: 3];
      dqsn_dis_q <= addr[EMR_DQSN_DIS];
    end
  end

  // open row tracking, sets status bit 1 (active power-down), which no core output reads
  always_ff @(posedge link_ck or negedge rst_ck_n)
  begin
    if (!rst_ck_n)
      row_open_q <= 1'b0;
    else if (cmd_ok && cmd == CMD_ACT)
      row_open_q <= 1'b1;
    else if (cmd_ok && cmd == CMD_PRE)
      row_open_q <= 1'b0;
  end

  // self refresh and power-down entry on low clock enable, exit on high
  always_ff @(posedge link_ck or negedge rst_ck_n)
  begin
    if (!rst_ck_n)
    begin
      sref_q <= 1'b0;
      pdn_q <= 1'b0;
    end
    else if (cke)
    begin
      sref_q <= 1'b0;
      pdn_q <= 1'b0;
    end
    else if (!sref_q && !pdn_q)
    begin
      sref_q <= (cmd == CMD_REF);
      pdn_q <= (cmd != CMD_REF);
    end
  end

  // one toggle per auto refresh, carried to the core clock
  always_ff @(posedge link_ck or negedge rst_ck_n)
  begin
    if (!rst_ck_n)
      ref_tgl_q <= 1'b0;
    else if (cmd_ok && cmd == CMD_REF)
      ref_tgl_q <= ~ref_tgl_q;
  end

  // read and write burst sequencing, latency then beats
  always_ff @(posedge link_ck or negedge rst_ck_n)
  begin
    if (!rst_ck_n)
    begin
      state_q <= DTR_IDLE;
      wait_q <= 4'h0;
      beat_q <= 4'h0;
    end
    else
    begin
      unique case (state_q)
        DTR_IDLE:
        begin
          beat_q <= 4'h0;
          if (cmd_ok && cmd == CMD_RD)
          begin
            state_q <= DTR_RWAIT;
            wait_q <= rl - 4'h1;
          end
          else if (cmd_ok && cmd == CMD_WR)
          begin
            state_q <= DTR_WWAIT;
            wait_q <= rl - 4'h2;
          end
        end
        DTR_RWAIT, DTR_WWAIT:
        begin
          if (wait_q == 4'h0)
            state_q <= (state_q == DTR_RWAIT) ? DTR_RBURST : DTR_WBURST;
          else
            wait_q <= wait_q - 4'h1;
        end
        DTR_RBURST, DTR_WBURST:
        begin
          beat_q <= beat_q + 4'h1;
          if (beat_q == beats - 4'h1)
            state_q <= DTR_IDLE;
        end
        default:
          state_q <= DTR_IDLE;
      endcase
    end
  end

  // write beats captured into the burst store
  always_ff @(posedge link_ck)
  begin
    if (state_q == DTR_WBURST)
      mem_q[beat_q[2:0]] <= dq_in;
  end

  // data and its enable share one edge so drive starts with the data
  always_ff @(posedge link_ck or negedge rst_ck_n)
  begin
    if (!rst_ck_n)
    begin
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
    end
    else if (state_q == DTR_RBURST)
    begin
      dq_out <= mem_q[beat_q[2:0]];
      dq_oe_n <= 1'b0;
    end
    else
    begin
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
    end
  end

  // strobe pair, complement is the exact inverse and floats with it, or alone when disabled
  always_ff @(posedge link_ck or negedge rst_ck_n)
  begin
    if (!rst_ck_n)
    begin
      dqs_out <= 1'b0;
      dqs_n_out <= 1'b1;
      dqs_oe_n <= 1'b1;
      dqs_n_oe_n <= 1'b1;
    end
    else
    begin
      dqs_out <= (state_q == DTR_RBURST) && !beat_q[0];
      dqs_n_out <= !((state_q == DTR_RBURST) && !beat_q[0]);
      dqs_oe_n <= (state_q != DTR_RBURST);
      dqs_n_oe_n <= (state_q != DTR_RBURST) || dqsn_dis_q;
    end
  end

  // status levels crossed into the core clock by two flip-flops
  assign stat_ck = {pd_slow_q, rtt_q != 2'h0, sref_q, pdn_q && row_open_q,
                    pdn_q};
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stat_s1_q <= 5'h00;
      stat_s2_q <= 5'h00;
    end
    else
    begin
      stat_s1_q <= stat_ck;
      stat_s2_q <= stat_s1_q;
    end
  end

  // calibration mode word crossed as a slow level, held between writes
  logic [2:0] ocd_s1_q;
  logic [2:0] ocd_s2_q;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ocd_s1_q <= 3'h0;
      ocd_s2_q <= 3'h0;
    end
    else
    begin
      ocd_s1_q <= ocd_q;
      ocd_s2_q <= ocd_s1_q;
    end
  end

  // refresh toggle synchronised, edge counted in the core clock
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_sync_q <= 3'h0;
      ref_cnt_q <= 16'h0000;
      ref_pulse_q <= 1'b0;
    end
    else
    begin
      ref_sync_q <= {ref_sync_q[1:0], ref_tgl_q};
      ref_pulse_q <= ref_sync_q[2] ^ ref_sync_q[1];
      if (ref_sync_q[2] ^ ref_sync_q[1])
        ref_cnt_q <= ref_cnt_q + 16'h0001;
    end
  end

  assign core_apd_slow = stat_s2_q[4];
  assign core_odt_on = stat_s2_q[3];
  assign core_self_refresh = stat_s2_q[2];
  assign core_power_down = stat_s2_q[0];
  assign core_ocd_mode = ocd_s2_q;
  assign core_refresh_pulse = ref_pulse_q;
  assign core_refresh_count = ref_cnt_q;
endmodule

//--- logic/dtr_pkg.sv
package dtr_pkg;
  // clock rates
  localparam int MCLK_NS = 20;
  localparam int LINK_CK_NS = 64;
  // driver calibration / termination change window, longest, rounds down but never below one cycle
  localparam int T_MOD_NS = 12;
  localparam int MOD_CYC_RAW = T_MOD_NS / LINK_CK_NS;
  localparam int MOD_CYC = (MOD_CYC_RAW < 1) ? 1 : MOD_CYC_RAW;
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  // bank select of mode register writes
  localparam logic [2:0] BA_MR = 3'h0;
  localparam logic [2:0] BA_EMR = 3'h1;
  // mode register fields
  localparam int MR_PD_BIT = 12;
  localparam int MR_CL_LSB = 4;
  localparam int MR_BL_LSB = 0;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  // extended mode register fields
  localparam int EMR_OCD_LSB = 7;
  localparam int EMR_AL_LSB = 3;
  localparam int EMR_RTT_HI = 6;
  localparam int EMR_RTT_LO = 2;
  localparam int EMR_DQSN_DIS = 10;
  // reset values, then beat counts and bus widths
  localparam logic [2:0] CL_RESET = 3'h3;
  localparam logic [2:0] AL_RESET = 3'h0;
  localparam logic [2:0] OCD_RESET = 3'h0;
  localparam logic [1:0] RTT_RESET = 2'h0;
  localparam logic [3:0] BEATS_4 = 4'h4;
  localparam logic [3:0] BEATS_8 = 4'h8;
  localparam int DQ_W = 8;
  localparam int ADDR_W = 14;
  localparam int STAT_W = 5;
  typedef enum logic [2:0] {
    DTR_IDLE = 3'b000,
    DTR_RWAIT = 3'b001,
    DTR_RBURST = 3'b010,
    DTR_WWAIT = 3'b011,
    DTR_WBURST = 3'b100
  } dtr_state_e;
endpackage

//--- testbench/dtr_asserts.sv
`timescale 1ns/10ps
// read drivers: strobe polarity, drive windows, burst shape
module dtr_asserts
  import dtr_pkg::*;
(
  input wire logic link_ck,
  input wire logic reset_n,
  input wire logic [DQ_W-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic dqs_out,
  input wire logic dqs_oe_n,
  input wire logic dqs_n_out
);
  default clocking cb @(posedge link_ck);
  endclocking
  default disable iff (!reset_n);
  // one high beat then one low beat while driving
  sequence s_pair;
    !dq_oe_n && dqs_out ##1 !dq_oe_n && !dqs_out;
  endsequence
  strobe_inv_a: assert property (dqs_n_out != dqs_out)
    else $error("complement strobe not inverse");
  drive_pair_a: assert property (dq_oe_n == dqs_oe_n)
    else $error("data and strobe drive apart");
  quiet_bus_a: assert property (dq_oe_n |-> dq_out == 0)
    else $error("data not idle while released");
  burst_shape_a: assert property ($fell(dq_oe_n) |-> s_pair ##1 s_pair)
    else $error("read burst shape wrong");
endmodule

//--- testbench/dtr_ctrl_model.sv
`timescale 1ns/10ps
// controller side: free running link clock and command driver
module dtr_ctrl_model
  import dtr_pkg::*;
(
  output logic link_ck,
  output logic cke,
  output logic [3:0] cmd,
  output logic [2:0] ba,
  output logic [ADDR_W-1:0] addr,
  output logic [DQ_W-1:0] dq_in
);
  // clock keeps running through power-down
  initial link_ck = 1'b0;
  always #(LINK_CK_NS/2) link_ck = ~link_ck;
  initial
  begin
    cke = 1'b1;
    cmd = 4'hf;
    ba = 3'h0;
    addr = 14'h0000;
    dq_in = 8'h00;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge link_ck);
  endtask
  // one command, then a deselect cycle before the next
  task automatic cmd_go(input logic [3:0] c, input logic [2:0] b,
    input logic [ADDR_W-1:0] a);
    @(negedge link_ck);
    cmd <= c;
    ba <= b;
    addr <= a;
    @(negedge link_ck);
    cmd <= 4'hf;
  endtask
  // write of four beats at write latency, line inverted after
  task automatic wr(input logic [DQ_W-1:0] v);
    cmd_go(CMD_WR, 3'h0, 14'h0000);
    idle(2);
    for (int i = 0; i < 4; i++)
    begin
      dq_in <= v + i[DQ_W-1:0];
      @(negedge link_ck);
    end
    dq_in <= ~dq_in;
    idle(2);
  endtask
  // clock enable change, held long enough for the slowest exit
  task automatic cke_set(input logic v, input logic [3:0] c);
    @(negedge link_ck);
    cke <= v;
    cmd <= c;
    @(negedge link_ck);
    cmd <= 4'hf;
    idle(8);
  endtask
endmodule

//--- testbench/dtr_device_tb.sv
`timescale 1ns/10ps
module dtr_device_tb;
  import dtr_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic link_ck, cke, dq_oe_n, dqs_out, dqs_oe_n, dqs_n_out, dqs_n_oe_n;
  logic core_apd_slow, core_odt_on, core_self_refresh, core_power_down;
  logic core_refresh_pulse;
  logic [3:0] cmd;
  logic [2:0] ba, core_ocd_mode;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_in, dq_out;
  logic [15:0] core_refresh_count;
  int mismatches = 0;
  int cmp_count = 0;
  int ref_pulses = 0;
  always #(MCLK_NS/2) mclk = ~mclk;
  // count core refresh pulses
  always @(posedge mclk)
    if (core_refresh_pulse === 1'b1)
      ref_pulses++;
  dtr_ctrl_model u_dtr_ctrl_model (.link_ck(link_ck), .cke(cke),
    .cmd(cmd), .ba(ba), .addr(addr), .dq_in(dq_in));
  dtr_device u_dtr_device (.mclk(mclk), .reset_n(reset_n),
    .link_ck(link_ck), .cke(cke), .cs_n(cmd[3]), .ras_n(cmd[2]),
    .cas_n(cmd[1]), .we_n(cmd[0]), .ba(ba), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dqs_out(dqs_out),
    .dqs_oe_n(dqs_oe_n), .dqs_n_out(dqs_n_out), .dqs_n_oe_n(dqs_n_oe_n),
    .core_apd_slow(core_apd_slow), .core_ocd_mode(core_ocd_mode),
    .core_odt_on(core_odt_on), .core_self_refresh(core_self_refresh),
    .core_power_down(core_power_down),
    .core_refresh_pulse(core_refresh_pulse),
    .core_refresh_count(core_refresh_count));
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // exit mode bit, calibration and termination fields
  task automatic t_mode();
    u_dtr_ctrl_model.cmd_go(CMD_MRS, BA_MR, 14'h1030);
    u_dtr_ctrl_model.cmd_go(CMD_MRS, BA_EMR, 14'h03c0);
    u_dtr_ctrl_model.idle(4);
    chk("apd_slow", core_apd_slow, 1'b1);
    chk("ocd", core_ocd_mode, 3'h7);
    chk("odt", core_odt_on, 1'b1);
    u_dtr_ctrl_model.cmd_go(CMD_MRS, BA_MR, 14'h0030);
    u_dtr_ctrl_model.cmd_go(CMD_MRS, BA_EMR, 14'h0000);
    u_dtr_ctrl_model.idle(4);
    chk("apd_fast", core_apd_slow, 1'b0);
    chk("ocd_off", core_ocd_mode, 3'h0);
    chk("odt_off", core_odt_on, 1'b0);
  endtask
  // write then read back four beats with strobe
  task automatic t_wr_rd();
    u_dtr_ctrl_model.cmd_go(CMD_ACT, 3'h0, 14'h0000);
    u_dtr_ctrl_model.wr(8'h5a);
    u_dtr_ctrl_model.cmd_go(CMD_RD, 3'h0, 14'h0000);
    u_dtr_ctrl_model.idle(4);
    for (int i = 0; i < 4; i++)
    begin
      chk("dq", dq_out, 8'h5a + i[7:0]);
      chk("dq_oe_n", dq_oe_n, 1'b0);
      chk("dqs", dqs_out, (i % 2) == 0);
      chk("dqs_n", dqs_n_out, (i % 2) != 0);
      chk("dqs_oe_n", dqs_oe_n, 1'b0);
      chk("dqs_n_oe_n", dqs_n_oe_n, 1'b0);
      u_dtr_ctrl_model.idle(1);
    end
    chk("dq_release", dq_oe_n, 1'b1);
    chk("dqs_release", dqs_oe_n, 1'b1);
  endtask
  // single ended strobe: complement stays released during a read
  task automatic t_strobe_off();
    u_dtr_ctrl_model.cmd_go(CMD_MRS, BA_EMR, 14'h0400);
    u_dtr_ctrl_model.cmd_go(CMD_RD, 3'h0, 14'h0000);
    u_dtr_ctrl_model.idle(4);
    for (int i = 0; i < 4; i++)
    begin
      chk("se_dqs_oe_n", dqs_oe_n, 1'b0);
      chk("se_dqs_n_oe_n", dqs_n_oe_n, 1'b1);
      u_dtr_ctrl_model.idle(1);
    end
    u_dtr_ctrl_model.cmd_go(CMD_MRS, BA_EMR, 14'h0000);
    u_dtr_ctrl_model.idle(2);
  endtask
  // two auto refreshes after closing the row
  task automatic t_refresh();
    u_dtr_ctrl_model.cmd_go(CMD_PRE, 3'h0, 14'h0400);
    u_dtr_ctrl_model.cmd_go(CMD_REF, 3'h0, 14'h0000);
    u_dtr_ctrl_model.idle(3);
    u_dtr_ctrl_model.cmd_go(CMD_REF, 3'h0, 14'h0000);
    u_dtr_ctrl_model.idle(3);
    chk("refresh_count", core_refresh_count, 16'h0002);
    chk("refresh_pulses", ref_pulses[15:0], 16'h0002);
  endtask
  // power-down and self refresh entry and exit
  task automatic t_power();
    u_dtr_ctrl_model.cke_set(1'b0, 4'hf);
    chk("pd_in", core_power_down, 1'b1);
    u_dtr_ctrl_model.cke_set(1'b1, 4'hf);
    chk("pd_out", core_power_down, 1'b0);
    u_dtr_ctrl_model.cke_set(1'b0, CMD_REF);
    chk("sr_in", core_self_refresh, 1'b1);
    u_dtr_ctrl_model.cke_set(1'b1, 4'hf);
    u_dtr_ctrl_model.idle(200);
    chk("sr_out", core_self_refresh, 1'b0);
  endtask
  initial
  begin
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    u_dtr_ctrl_model.idle(4);
    t_mode();
    t_wr_rd();
    t_strobe_off();
    t_refresh();
    t_power();
    print_verdict();
  end
  // watchdog well past the expected run
  initial
  begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule
bind dtr_device dtr_asserts u_dtr_asserts (.link_ck(link_ck),
  .reset_n(reset_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
  .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .dqs_n_out(dqs_n_out));
